// file: sqbi_core.sv
// Purpose: Logic of a separate-I/O burst-of-four SRAM behind its pins,
//          with an APB register view.
// Assumes: All pins sampled by i_sys_clk through two flip-flops.
// Notes:   Write bursts pass through a FIFO into a small array.
// Function
// - The word address is taken at a rising master clock edge that starts a command.
// - Write data is taken on rising edges of both write clocks of a pair.
// - Write bits 17:0 exist in both organizations, 35:18 only when wide.
// - Read data moves on echo clock edges, bits above 17 only when wide.
// - Read-valid rises one half master cycle before the first beat.
// - Write pair 0 takes the low lane bits, pair 1 the high lane bits.
// - Echo clock pairs run freely except under the reset pin, and go with the two read lanes.
// - A low read request at a master rising edge starts a read.
// - A low write request at a master rising edge starts a write.
// - Read and output timing follows the master clock pair; write data capture follows the write clocks.
// - The clock loop is on when its strap is high, off when low.
// - The reset pin holds the device inactive and clears its command and read state, not its counters.
// - Termination mode 00 is off, 01 strong, 10 weak, 11 reserved.
// - Group 00 data, 01 plus clocks, 10 plus address, 11 everything.
// - During reset the loop is off and requests are ignored.
`timescale 1ns/1ps
`include "sqbi_defines.svh"
module sqbi_core #(
  parameter int ADDR_W = 20,
  parameter int MEM_DEPTH = 256,
  parameter int RD_LAT = 2,
  parameter int FIFO_DEPTH = 8
) (
  // System clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Master clock pair and commands
  input wire logic i_master_clock_pair_t,
  input wire logic i_master_clock_pair_c,
  input wire logic [ADDR_W-1:0] i_word_address,
  input wire logic i_rd_req_n,
  input wire logic i_wr_req_n,
  // Write data and its clocks
  input wire logic [1:0] i_write_capture_clock_t,
  input wire logic [1:0] i_write_capture_clock_c,
  input wire logic [35:0] i_wdata,
  // Straps and reset pin
  input wire logic i_loop_en,
  input wire logic i_dev_reset,
  input wire logic [1:0] i_termination_mode_select,
  input wire logic [1:0] i_termination_group_select,
  // Read side
  output logic [35:0] o_rdata,
  output logic [1:0] o_read_valid_flag,
  output logic [1:0] o_read_echo_clock_t,
  output logic [1:0] o_read_echo_clock_c,
  // Clock loop and termination state
  output logic o_loop_active,
  output logic o_term_strong,
  output logic o_term_weak,
  output logic o_term_wdata,
  output logic o_term_clk,
  output logic o_term_addr_ctrl
);
  localparam int PINW = 14 + ADDR_W + 36;
  localparam int MAW = $clog2(MEM_DEPTH);
  localparam int BW = `SQBI_DW * `SQBI_BEATS;
  localparam int FW = ADDR_W + BW;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  localparam int HV = 2 * RD_LAT - 1;
  // Idle pin levels, so no false edge or request follows reset
  localparam logic [PINW-1:0] PIN_IDLE = {6'h03, 2'h3,
    {(PINW - 8){1'b0}}};

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [PINW-1:0] pin_raw, pin_s1_reg, pin_s2_reg;
  logic [5:0] clk_prev_reg;
  logic mck_t, mck_c, rd_n_s, wr_n_s, loop_en_s, rst_pin_s;
  logic [1:0] wck_t, wck_c, mode_s, group_s, wbeat;
  logic [ADDR_W-1:0] addr_s;
  logic [35:0] wdata_s;
  logic mclk_rise, half_edge, active;

  assign pin_raw = {i_master_clock_pair_t, i_master_clock_pair_c,
    i_write_capture_clock_t, i_write_capture_clock_c, i_rd_req_n,
    i_wr_req_n, i_loop_en, i_dev_reset, i_termination_mode_select,
    i_termination_group_select, i_word_address, i_wdata};
  assign {mck_t, mck_c, wck_t, wck_c, rd_n_s, wr_n_s, loop_en_s, rst_pin_s,
    mode_s, group_s, addr_s, wdata_s} = pin_s2_reg;

  // Two-stage sampling and clock history
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      pin_s1_reg <= PIN_IDLE;
      pin_s2_reg <= PIN_IDLE;
      clk_prev_reg <= 6'h03;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      clk_prev_reg <= {mck_t, mck_c, wck_t, wck_c};
    end
  end

  // Edges of master pair and write pairs
  assign mclk_rise = mck_t & ~clk_prev_reg[5];
  assign half_edge = mclk_rise | (mck_c & ~clk_prev_reg[4]);
  assign wbeat = (wck_t & ~clk_prev_reg[3:2]) | (wck_c & ~clk_prev_reg[1:0]);

  // ----------------------------------------
  // Control registers and device activity
  // ----------------------------------------
  logic [1:0] ctrl_reg, ctrl_next;
  logic wide, loop_reg, loop_next;
  assign wide = ctrl_reg[`SQBI_CTRL_WIDE];
  assign active = ~rst_pin_s & ~ctrl_reg[`SQBI_CTRL_HOLD];

  // Loop follows strap unless reset pin held
  always_comb begin
    loop_next = loop_en_s & ~rst_pin_s;
  end

  // ----------------------------------------
  // Write command and lane capture
  // ----------------------------------------
  logic wr_pend_reg, wr_pend_next, wr_start, wr_push;
  logic [ADDR_W-1:0] wr_addr_reg, wr_addr_next;
  logic [1:0] lane_done;
  logic [BW-1:0] lane_beats [2];
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [FW-1:0] fifo_out_data;
  logic [LW-1:0] fifo_level;
  logic [15:0] wcnt_reg, wcnt_next, drop_reg, drop_next;

  assign wr_start = active & mclk_rise & ~wr_n_s & ~wr_pend_reg;
  assign wr_push = wr_pend_reg & (&lane_done);

  genvar l;
  generate
    for (l = 0; l < 2; l++) begin : g_lane
      logic [1:0] cnt_reg, cnt_next;
      logic done_reg, done_next;
      logic [BW-1:0] bt_reg, bt_next;
      logic [35:0] mask;
      // Lane bits depend on organization
      assign mask = wide
        ? {{18{1'b0}}, {18{1'b1}}} << (l * `SQBI_WIDE_LANE)
        : {{27{1'b0}}, {9{1'b1}}} << (l * `SQBI_NARROW_LANE);
      always_comb begin
        cnt_next = cnt_reg;
        done_next = done_reg;
        bt_next = bt_reg;
        if (wr_start) begin
          cnt_next = 2'h0;
          done_next = 1'b0;
          bt_next = '0;
        end else if (wr_pend_reg && !done_reg && wbeat[l]) begin
          bt_next[cnt_reg*`SQBI_DW +: `SQBI_DW] = wdata_s & mask;
          cnt_next = cnt_reg + 2'h1;
          done_next = (cnt_reg == 2'h3);
        end
      end
      always_ff @(posedge i_sys_clk) begin
        if (!i_rstn || rst_pin_s) begin
          cnt_reg <= 2'h0;
          done_reg <= 1'b0;
          bt_reg <= '0;
        end else begin
          cnt_reg <= cnt_next;
          done_reg <= done_next;
          bt_reg <= bt_next;
        end
      end
      assign lane_done[l] = done_reg;
      assign lane_beats[l] = bt_reg;
    end
  endgenerate

  // Write command bookkeeping
  always_comb begin
    wr_pend_next = wr_pend_reg;
    wr_addr_next = wr_addr_reg;
    wcnt_next = wcnt_reg;
    drop_next = drop_reg;
    if (wr_start) begin
      wr_pend_next = 1'b1;
      wr_addr_next = addr_s;
    end else if (wr_push) begin
      wr_pend_next = 1'b0;
      if (fifo_in_ready) begin
        wcnt_next = wcnt_reg + 16'h0001;
      end else begin
        drop_next = drop_reg + 16'h0001;
      end
    end
  end

  sqbi_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_valid(wr_push),
    .o_ready(fifo_in_ready),
    .i_data({wr_addr_reg, lane_beats[1] | lane_beats[0]}),
    .o_valid(fifo_out_valid),
    .i_ready(fifo_out_ready),
    .o_data(fifo_out_data),
    .o_level(fifo_level)
  );

  // ----------------------------------------
  // Array and read sequencer
  // ----------------------------------------
  logic [BW-1:0] mem [MEM_DEPTH];
  sqbi_pkg::sqbi_rd_state_e rd_state_reg, rd_state_next;
  logic rd_start, valid_reg, valid_next;
  logic [ADDR_W-1:0] rd_addr;
  logic [BW-1:0] rd_word_reg, rd_word_next;
  logic [31:0] hcnt_reg, hcnt_next;
  logic [1:0] beat_reg, beat_next;
  logic [35:0] rdata_reg, rdata_next, qmask;
  logic [15:0] rcnt_reg, rcnt_next;

  assign rd_start = active & mclk_rise & ~rd_n_s
    & (rd_state_reg == sqbi_pkg::RD_IDLE);
  assign rd_addr = addr_s;
  assign fifo_out_ready = ~rd_start;
  assign qmask = wide ? {36{1'b1}} : {{18{1'b0}}, {18{1'b1}}};

  // Read sequencing on master half-cycle edges
  always_comb begin
    rd_state_next = rd_state_reg;
    rd_word_next = rd_word_reg;
    hcnt_next = hcnt_reg;
    beat_next = beat_reg;
    valid_next = valid_reg;
    rdata_next = rdata_reg;
    rcnt_next = rcnt_reg;
    case (rd_state_reg)
      sqbi_pkg::RD_IDLE: begin
        if (rd_start) begin
          rd_word_next = mem[rd_addr[MAW-1:0]];
          hcnt_next = 32'h0000_0000;
          rcnt_next = rcnt_reg + 16'h0001;
          rd_state_next = sqbi_pkg::RD_WAIT;
        end
      end
      sqbi_pkg::RD_WAIT: begin
        if (half_edge) begin
          hcnt_next = hcnt_reg + 32'h0000_0001;
          if (hcnt_reg == HV - 1) begin
            valid_next = 1'b1;
            rd_state_next = sqbi_pkg::RD_LEAD;
          end
        end
      end
      sqbi_pkg::RD_LEAD: begin
        if (half_edge) begin
          rdata_next = rd_word_reg[0 +: `SQBI_DW] & qmask;
          beat_next = 2'h1;
          rd_state_next = sqbi_pkg::RD_BURST;
        end
      end
      sqbi_pkg::RD_BURST: begin
        if (half_edge) begin
          if (beat_reg == 2'h0) begin
            rdata_next = '0;
            rd_state_next = sqbi_pkg::RD_IDLE;
          end else begin
            rdata_next = rd_word_reg[beat_reg*`SQBI_DW +: `SQBI_DW] & qmask;
            beat_next = beat_reg + 2'h1;
            valid_next = (beat_reg != 2'h3);
          end
        end
      end
      default: rd_state_next = sqbi_pkg::RD_IDLE;
    endcase
  end

  // Read sequencer registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn || rst_pin_s) begin
      rd_state_reg <= sqbi_pkg::RD_IDLE;
      rd_word_reg <= '0;
      hcnt_reg <= 32'h0000_0000;
      beat_reg <= 2'h0;
      valid_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      rd_state_reg <= rd_state_next;
      rd_word_reg <= rd_word_next;
      hcnt_reg <= hcnt_next;
      beat_reg <= beat_next;
      valid_reg <= valid_next;
      rdata_reg <= rdata_next;
    end
  end

  // Array write from FIFO, stalled by a read fetch
  always_ff @(posedge i_sys_clk) begin
    if (fifo_out_valid && fifo_out_ready) begin
      mem[fifo_out_data[BW +: MAW]] <= fifo_out_data[BW-1:0];
    end
  end

  // ----------------------------------------
  // Termination decode and echo clocks
  // ----------------------------------------
  logic [4:0] term_reg, term_next;
  logic [1:0] echo_reg, echo_next;
  always_comb begin
    term_next = 5'h00;
    if (mode_s == `SQBI_TERM_STRONG || mode_s == `SQBI_TERM_WEAK) begin
      term_next[0] = (mode_s == `SQBI_TERM_STRONG);
      term_next[1] = (mode_s == `SQBI_TERM_WEAK);
      term_next[2] = 1'b1;
      term_next[3] = group_s[`SQBI_GRP_CLK];
      term_next[4] = group_s[`SQBI_GRP_ADDR];
    end
    echo_next = rst_pin_s ? 2'b00 : {mck_t, mck_c};
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic [31:0] prdata_reg, prdata_next, status;
  logic mapped;
  assign status = {19'h0_0000, mode_s == 2'h3, group_s, mode_s,
    {(4 - LW){1'b0}}, fifo_level, rd_state_reg != sqbi_pkg::RD_IDLE,
    wr_pend_reg, rst_pin_s, loop_reg};
  assign mapped = (i_paddr == `SQBI_OFF_CTRL) || (i_paddr == `SQBI_OFF_STATUS)
    || (i_paddr == `SQBI_OFF_WR_COUNT) || (i_paddr == `SQBI_OFF_RD_COUNT)
    || (i_paddr == `SQBI_OFF_DROP_COUNT);

  // Register writes and read data staged in setup phase
  always_comb begin
    ctrl_next = ctrl_reg;
    prdata_next = prdata_reg;
    if (i_psel && i_penable && i_pwrite
        && i_paddr == `SQBI_OFF_CTRL) begin
      ctrl_next = i_pwdata[1:0];
    end
    if (i_psel && !i_penable) begin
      if (i_paddr == `SQBI_OFF_CTRL) begin
        prdata_next = {30'h0000_0000, ctrl_reg};
      end else if (i_paddr == `SQBI_OFF_STATUS) begin
        prdata_next = status;
      end else if (i_paddr == `SQBI_OFF_WR_COUNT) begin
        prdata_next = {16'h0000, wcnt_reg};
      end else if (i_paddr == `SQBI_OFF_RD_COUNT) begin
        prdata_next = {16'h0000, rcnt_reg};
      end else if (i_paddr == `SQBI_OFF_DROP_COUNT) begin
        prdata_next = {16'h0000, drop_reg};
      end else begin
        prdata_next = 32'h0000_0000;
      end
    end
  end

  // Remaining registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      ctrl_reg <= `SQBI_CTRL_RESET;
      prdata_reg <= 32'h0000_0000;
      loop_reg <= 1'b0;
      term_reg <= 5'h00;
      echo_reg <= 2'b00;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      wcnt_reg <= 16'h0000;
      drop_reg <= 16'h0000;
      rcnt_reg <= 16'h0000;
    end else begin
      ctrl_reg <= ctrl_next;
      prdata_reg <= prdata_next;
      loop_reg <= loop_next;
      term_reg <= term_next;
      echo_reg <= echo_next;
      wr_pend_reg <= wr_pend_next & ~rst_pin_s;
      wr_addr_reg <= wr_addr_next;
      wcnt_reg <= wcnt_next;
      drop_reg <= drop_next;
      rcnt_reg <= rcnt_next;
    end
  end

  // Outputs
  assign o_prdata = prdata_reg;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;
  assign o_rdata = rdata_reg;
  assign o_read_valid_flag = {2{valid_reg}};
  assign o_read_echo_clock_t = {2{echo_reg[1]}};
  assign o_read_echo_clock_c = {2{echo_reg[0]}};
  assign o_loop_active = loop_reg;
  assign {o_term_addr_ctrl, o_term_clk, o_term_wdata, o_term_weak,
    o_term_strong} = term_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  chk_rst_loop_off: assert property (rst_pin_s |=> !o_loop_active)
    else $error("loop active under reset pin");
  chk_loop_strap: assert property (
    !rst_pin_s && loop_en_s |=> o_loop_active)
    else $error("loop not enabled by strap");
  chk_rst_no_cmd: assert property (rst_pin_s |=>
    rd_state_reg == sqbi_pkg::RD_IDLE && !wr_pend_reg && !valid_reg)
    else $error("command state kept under reset pin");
  chk_rd_cause: assert property (mclk_rise && !rd_n_s && active
    && rd_state_reg == sqbi_pkg::RD_IDLE
    |=> rd_state_reg == sqbi_pkg::RD_WAIT)
    else $error("read request at edge not started");
  chk_wr_cause: assert property (wr_start |=> wr_pend_reg
    && wr_addr_reg == $past(addr_s))
    else $error("write command not latched");
  chk_valid_lead: assert property ($rose(valid_reg) |-> ##1
    rd_state_reg == sqbi_pkg::RD_LEAD && rdata_reg == 36'h0_0000_0000)
    else $error("valid not ahead of data");
  chk_narrow_read: assert property (!wide |->
    o_rdata[35:18] == 18'h0_0000)
    else $error("upper read bits driven in narrow mode");
  chk_narrow_write: assert property (wr_push && !wide
    |-> lane_beats[1][35:18] == 18'h0_0000)
    else $error("upper write bits kept in narrow mode");
  chk_burst_end: assert property (rd_state_reg == sqbi_pkg::RD_BURST
    && half_edge && beat_reg == 2'h3 |=> !valid_reg)
    else $error("valid outlasts burst");
  chk_term_off: assert property (mode_s == `SQBI_TERM_OFF
    |=> !o_term_strong && !o_term_weak && !o_term_wdata)
    else $error("termination on in off mode");
  chk_term_all: assert property (mode_s == `SQBI_TERM_WEAK
    && group_s == 2'h3 |=> o_term_clk && o_term_addr_ctrl && o_term_weak)
    else $error("group all not decoded");

  cov_read_burst: cover property ($fell(valid_reg));
  cov_write_push: cover property (wr_push && fifo_in_ready);
  cov_write_drop: cover property (wr_push && !fifo_in_ready);
  cov_fifo_stall: cover property (fifo_out_valid && rd_start);
endmodule

// file: sqbi_defines.svh
// Purpose: Offsets, field positions, reset values and codes for the
//          burst SRAM pin interface.
// Assumes: Included by its bare name.
// Notes:   Definitions only.
`ifndef SQBI_DEFINES_SVH
`define SQBI_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SQBI_OFF_CTRL 12'h000
`define SQBI_OFF_STATUS 12'h004
`define SQBI_OFF_WR_COUNT 12'h008
`define SQBI_OFF_RD_COUNT 12'h00C
`define SQBI_OFF_DROP_COUNT 12'h010

// ----------------------------------------
// Control fields and reset value
// ----------------------------------------
`define SQBI_CTRL_WIDE 0
`define SQBI_CTRL_HOLD 1
`define SQBI_CTRL_RESET 2'h1

// ----------------------------------------
// Status fields
// ----------------------------------------
`define SQBI_ST_LOOP 0
`define SQBI_ST_RST 1
`define SQBI_ST_WPEND 2
`define SQBI_ST_RBUSY 3
`define SQBI_ST_LEVEL 4
`define SQBI_ST_MODE 8
`define SQBI_ST_GROUP 10
`define SQBI_ST_RSVD 12

// ----------------------------------------
// Termination codes
// ----------------------------------------
`define SQBI_TERM_OFF 2'h0
`define SQBI_TERM_STRONG 2'h1
`define SQBI_TERM_WEAK 2'h2
`define SQBI_GRP_CLK 0
`define SQBI_GRP_ADDR 1

// ----------------------------------------
// Data layout
// ----------------------------------------
`define SQBI_DW 36
`define SQBI_BEATS 4
`define SQBI_WIDE_LANE 18
`define SQBI_NARROW_LANE 9

`endif

// file: sqbi_pkg.sv
// Purpose: Types shared by the burst SRAM pin interface.
// Assumes: Nothing else.
// Notes:   Constants live in the defines header.
package sqbi_pkg;

  // ----------------------------------------
  // Read sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_WAIT,
    RD_LEAD,
    RD_BURST
  } sqbi_rd_state_e;

endpackage

// file: sqbi_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Output data read straight from the array.
`timescale 1ns/1ps
module sqbi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data,
  // Fill level
  output logic [$clog2(DEPTH):0] o_level
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic push, pop;

  // Handshakes and flags
  assign o_level = wptr_reg - rptr_reg;
  assign o_ready = (o_level != DEPTH[PW:0]);
  assign o_valid = (wptr_reg != rptr_reg);
  assign o_data = mem[rptr_reg[PW-1:0]];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  // Pointer next values
  always_comb begin
    wptr_next = wptr_reg + {{PW{1'b0}}, push};
    rptr_next = rptr_reg + {{PW{1'b0}}, pop};
  end

  // Pointer registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
    end
  end

  // Storage
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wptr_reg[PW-1:0]] <= i_data;
    end
  end
endmodule

// file: sqbi_ctrl_model.sv
// Purpose: Memory controller model that drives the SRAM pins.
// Assumes: Master clock runs free with a 125 ns period.
// Notes:   Released address and data pins show the inverse of their last value.
`timescale 1ns/1ps
module sqbi_ctrl_model (
  // Master clock and commands
  output logic o_mcp_t,
  output logic o_mcp_c,
  output logic [19:0] o_addr,
  output logic o_rd_n,
  output logic o_wr_n,
  // Write data and its clocks
  output logic [1:0] o_wcc_t,
  output logic [1:0] o_wcc_c,
  output logic [35:0] o_wdata
);
  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Idle levels, then a free clock of arbitrary phase
  initial begin
    o_mcp_t = 1'b0;
    o_addr = 20'h0_0000;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_wcc_t = 2'b00;
    o_wcc_c = 2'b11;
    o_wdata = 36'h0_0000_0000;
    #3;
    forever #62.5 o_mcp_t = ~o_mcp_t;
  end
  assign o_mcp_c = ~o_mcp_t;

  // One command around one master rise, then released
  task automatic command(input logic rd, input logic [19:0] a);
    @(negedge o_mcp_t);
    o_addr = a;
    o_rd_n = !rd;
    o_wr_n = rd;
    @(negedge o_mcp_t);
    o_addr = ~a;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
  endtask

  // Write command, then four beats on alternate clock rises
  task automatic write_burst(input logic [19:0] a, input logic [143:0] d);
    command(1'b0, a);
    for (int i = 0; i < 4; i++) begin
      o_wdata = d[36*i +: 36];
      #30;
      o_wcc_t = ~o_wcc_t;
      o_wcc_c = ~o_wcc_c;
      #30;
    end
    o_wdata = ~o_wdata;
  endtask
endmodule

// file: tb.sv
// Purpose: Self-checking bench for the burst SRAM pin interface.
// Assumes: Default design parameters, wide organization at reset.
// Notes:   Termination straps change only while the reset pin is held.
`timescale 1ns/1ps
`include "sqbi_defines.svh"
module tb;
  logic i_sys_clk, i_rstn, i_psel, i_penable, i_pwrite, o_pready;
  logic o_pslverr, mcp_t, mcp_c, rd_n, wr_n, loop_en, dev_reset;
  logic loop_act, t_str, t_weak, t_wd, t_clk, t_adr, on, e, rec_last;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, q;
  logic [19:0] addr;
  logic [1:0] wcc_t, wcc_c, mode, grp, rvalid, rec_t, rec_c;
  logic [35:0] wdata, rdata;
  logic [143:0] pat;
  int failures, compares;

  sqbi_ctrl_model u_ctrl (.o_mcp_t(mcp_t), .o_mcp_c(mcp_c), .o_addr(addr),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_wcc_t(wcc_t), .o_wcc_c(wcc_c),
    .o_wdata(wdata));
  sqbi_core dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_master_clock_pair_t(mcp_t),
    .i_master_clock_pair_c(mcp_c), .i_word_address(addr),
    .i_rd_req_n(rd_n), .i_wr_req_n(wr_n), .i_write_capture_clock_t(wcc_t),
    .i_write_capture_clock_c(wcc_c), .i_wdata(wdata), .i_loop_en(loop_en),
    .i_dev_reset(dev_reset), .i_termination_mode_select(mode),
    .i_termination_group_select(grp), .o_rdata(rdata),
    .o_read_valid_flag(rvalid), .o_read_echo_clock_t(rec_t),
    .o_read_echo_clock_c(rec_c), .o_loop_active(loop_act),
    .o_term_strong(t_str), .o_term_weak(t_weak), .o_term_wdata(t_wd),
    .o_term_clk(t_clk), .o_term_addr_ctrl(t_adr));

  // System clock
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bounded clock step of a wait
  task automatic step(inout int n);
    n++;
    @(posedge i_sys_clk);
    if (n > 400) begin
      failures++;
      end_of_test();
    end
  endtask

  // APB transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    step(n);
    while (o_pready !== 1'b1) step(n);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  // Read command, then four beats and the idle beat on echo edges
  task automatic read_check(input logic [19:0] a, input logic [143:0] d);
    int n;
    n = 0;
    u_ctrl.command(1'b1, a);
    while (rvalid !== 2'b11) step(n);
    repeat (3) @(posedge i_sys_clk);
    for (int k = 0; k < 5; k++) begin
      rec_last = rec_t[0];
      while (rec_t[0] === rec_last) step(n);
      repeat (2) @(posedge i_sys_clk);
      check(rdata, (k < 4) ? d[36*k +: 36] : 36'h0_0000_0000);
      check({rec_t, rec_c}, {{2{~rec_last}}, {2{rec_last}}});
      check({34'h0, rvalid}, (k < 3) ? 36'h3 : 36'h0);
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    failures = 0;
    compares = 0;
    {i_rstn, i_psel, i_penable, i_pwrite, dev_reset} = 5'b0_0000;
    {i_paddr, i_pwdata, loop_en, mode, grp} = 49'h0_0000_0000_0000;
    loop_en = 1'b1;
    pat = {36'h1_2345_6789, 36'h9_abcd_ef01, 36'h5_5aa5_33cc,
           36'ha_0f0f_1234};
    repeat (16) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    @(posedge i_sys_clk);
    apb(1'b0, `SQBI_OFF_CTRL, 32'h0);
    check(q, 36'h1);
    apb(1'b0, 12'h014, 32'h0);
    check({e, q}, 36'h1_0000_0000);
    u_ctrl.write_burst(20'h0_0005, pat);
    repeat (40) @(posedge i_sys_clk);
    read_check(20'h0_0005, pat);
    apb(1'b1, `SQBI_OFF_CTRL, 32'h0);
    u_ctrl.write_burst(20'h0_0006, ~pat);
    repeat (40) @(posedge i_sys_clk);
    read_check(20'h0_0006, ~pat & {4{36'h0_0003_ffff}});
    apb(1'b1, `SQBI_OFF_CTRL, 32'h3);
    u_ctrl.write_burst(20'h0_0005, ~pat);
    repeat (40) @(posedge i_sys_clk);
    apb(1'b1, `SQBI_OFF_CTRL, 32'h1);
    read_check(20'h0_0005, pat);
    apb(1'b0, `SQBI_OFF_RD_COUNT, 32'h0);
    check(q, 36'h3);
    // Reset pin held: loop off, echo still, write command ignored
    dev_reset <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    check({loop_act, rec_t, rec_c}, 36'h0);
    u_ctrl.write_burst(20'h0_0007, pat);
    apb(1'b0, `SQBI_OFF_WR_COUNT, 32'h0);
    check(q, 36'h2);
    for (int m = 0; m < 4; m++) begin
      for (int g = 0; g < 4; g++) begin
        mode <= m[1:0];
        grp <= g[1:0];
        repeat (6) @(posedge i_sys_clk);
        on = (m == 1 || m == 2);
        check({t_str, t_weak, t_wd, t_clk, t_adr},
              {m == 1, m == 2, on, on && g[0], on && g[1]});
      end
    end
    apb(1'b0, `SQBI_OFF_STATUS, 32'h0);
    check(q[12:8], 36'h1f);
    dev_reset <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    check(loop_act, 1'b1);
    loop_en <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    check(loop_act, 1'b0);
    end_of_test();
  end
endmodule
